// >>> design/flash_read_regs.vh
`ifndef FLASH_READ_REGS_VH
`define FLASH_READ_REGS_VH
`define OP_LEGACY_READ 8'he8
`define OP_FAST_READ 8'h0b
`define OP_SLOW_READ 8'h03
`define OP_PAGE_READ 8'hd2
`define OPCODE_BITS 6'h08
`define HEADER_BITS 6'h20
`define DUMMY_ONE 6'h08
`define DUMMY_FOUR 6'h20
`define PAGE_BYTES_STD 10'h210
`define PAGE_BYTES_BIN 10'h200
`define LAST_PAGE 12'hfff
`define BIT_INDEX_TOP 3'h7
`define STD_PAGE_LO 10
`define BIN_PAGE_LO 9
`endif

// >>> design/serial_flash_read.v
`timescale 1ns/1ps
`include "flash_read_regs.vh"
module serial_flash_read #(
   parameter PAGE_BITS = 12,
   parameter MEM_BYTES = 16
) (
   // system
   input wire clk,
   input wire rst_n,
   // serial pins from host
   input wire chipSelect_n,
   input wire serialClock,
   input wire serialIn,
   input wire resetPin_n,
   // configuration
   input wire binaryPageMode,
   // serial output pin
   output reg serialOut,
   output reg serialOutEnable_n,
   // status
   output reg readActive
);
   localparam ST_IDLE = 2'h0;
   localparam ST_HEADER = 2'h1;
   localparam ST_DUMMY = 2'h2;
   localparam ST_DATA = 2'h3;

   // small array stands in for the main memory contents
   reg [7:0] mainMemory [0:MEM_BYTES-1];
   integer i;
   initial begin
      for (i = 0; i < MEM_BYTES; i = i + 1) begin
         mainMemory[i] = i[7:0] ^ 8'h5a;
      end
   end

   // pin synchronisers: two stages, a third for edges
   reg [2:0] csSync;
   reg [2:0] sckSync;
   reg [2:0] siSync;
   reg [1:0] rstSync;

   // command state
   reg [1:0] state;
   reg [31:0] shiftIn;
   reg [5:0] bitCount;
   reg [5:0] dummyBits;
   reg [7:0] opcode;
   reg pageWrap;
   reg [PAGE_BITS-1:0] pageNumber;
   reg [9:0] byteOffset;
   reg [2:0] bitIndex;

   // next values of the command state and pins
   reg [1:0] next_state;
   reg [31:0] next_shiftIn;
   reg [5:0] next_bitCount;
   reg [5:0] next_dummyBits;
   reg [7:0] next_opcode;
   reg next_pageWrap;
   reg [PAGE_BITS-1:0] next_pageNumber;
   reg [9:0] next_byteOffset;
   reg [2:0] next_bitIndex;
   reg next_serialOut;
   reg next_serialOutEnable_n;
   reg next_readActive;

   // page bits take part so page moves show in the data
   function [7:0] fetchByte;
      input [PAGE_BITS-1:0] pg;
      input [9:0] off;
      begin
         fetchByte = mainMemory[{pg[1:0], off[1:0]}];
      end
   endfunction

   // last offset of a page in the chosen page size
   function [9:0] lastOffset;
      input bin;
      begin
         if (bin) begin
            lastOffset = `PAGE_BYTES_BIN - 10'h001;
         end else begin
            lastOffset = `PAGE_BYTES_STD - 10'h001;
         end
      end
   endfunction

   // page field of the address, unused top bits dropped
   function [PAGE_BITS-1:0] pageOf;
      input [23:0] addr;
      input bin;
      begin
         if (bin) begin
            pageOf = addr[`BIN_PAGE_LO +: PAGE_BITS];
         end else begin
            pageOf = addr[`STD_PAGE_LO +: PAGE_BITS];
         end
      end
   endfunction

   // starting byte within the page
   function [9:0] offsetOf;
      input [23:0] addr;
      input bin;
      begin
         if (bin) begin
            offsetOf = {1'b0, addr[`BIN_PAGE_LO-1:0]};
         end else begin
            offsetOf = addr[`STD_PAGE_LO-1:0];
         end
      end
   endfunction

   // page after the current one; page reads stay put
   function [PAGE_BITS-1:0] nextPage;
      input [PAGE_BITS-1:0] pg;
      input stay;
      begin
         if (stay) begin
            nextPage = pg;
         end else if (pg == {PAGE_BITS{1'b1}}) begin
            nextPage = {PAGE_BITS{1'b0}};
         end else begin
            nextPage = pg + {{(PAGE_BITS-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   // dummy bits that follow the address for each opcode
   function [5:0] dummyFor;
      input [7:0] op;
      begin
         if (op == `OP_FAST_READ) begin
            dummyFor = `DUMMY_ONE;
         end else if (op == `OP_LEGACY_READ) begin
            dummyFor = `DUMMY_FOUR;
         end else if (op == `OP_PAGE_READ) begin
            dummyFor = `DUMMY_FOUR;
         end else begin
            dummyFor = 6'h00;
         end
      end
   endfunction

   // opcodes that this block answers
   function knownRead;
      input [7:0] op;
      begin
         knownRead = (op == `OP_SLOW_READ) || (op == `OP_FAST_READ) ||
            (op == `OP_LEGACY_READ) || (op == `OP_PAGE_READ);
      end
   endfunction

   // pin views after synchronisation
   wire csLow = ~csSync[1];
   wire csFall = ~csSync[1] & csSync[2];
   // mode 0 and 3 both sample on rising, shift on falling
   wire sckRise = sckSync[1] & ~sckSync[2];
   wire sckFall = ~sckSync[1] & sckSync[2];
   wire siBit = siSync[1];
   wire rstPinLow = ~rstSync[1];

   // header and data position decodes
   wire opcodeDone = (bitCount == `OPCODE_BITS - 6'h01);
   wire headerDone = (bitCount == `HEADER_BITS - 6'h01);
   wire dummyDone = (bitCount == dummyBits - 6'h01);
   wire byteDone = (bitIndex == 3'h0);
   wire pageEnd = (byteOffset == lastOffset(binaryPageMode));

   // address as it stands when the last header bit arrives
   wire [23:0] addrField = {shiftIn[22:0], siBit};
   wire [7:0] curByte = fetchByte(pageNumber, byteOffset);

   // raw pins pass two flops before any logic reads them
   always @(posedge clk) begin
      csSync <= {csSync[1:0], chipSelect_n};
   end

   always @(posedge clk) begin
      sckSync <= {sckSync[1:0], serialClock};
   end

   always @(posedge clk) begin
      siSync <= {siSync[1:0], serialIn};
   end

   always @(posedge clk) begin
      rstSync <= {rstSync[0], resetPin_n};
   end

   // next state and output values
   always @* begin
      next_state = state;
      next_shiftIn = shiftIn;
      next_bitCount = bitCount;
      next_dummyBits = dummyBits;
      next_opcode = opcode;
      next_pageWrap = pageWrap;
      next_pageNumber = pageNumber;
      next_byteOffset = byteOffset;
      next_bitIndex = bitIndex;
      next_serialOut = serialOut;
      next_serialOutEnable_n = serialOutEnable_n;
      next_readActive = readActive;
      case (state)
         ST_IDLE: begin
            if (csFall) begin
               next_state = ST_HEADER;
               next_bitCount = 6'h00;
            end
         end
         ST_HEADER: begin
            if (sckRise) begin
               next_shiftIn = {shiftIn[30:0], siBit};
               next_bitCount = bitCount + 6'h01;
               if (opcodeDone) begin
                  next_opcode = {shiftIn[6:0], siBit};
               end
               if (headerDone) begin
                  next_bitCount = 6'h00;
                  next_bitIndex = `BIT_INDEX_TOP;
                  next_pageNumber = pageOf(addrField, binaryPageMode);
                  next_byteOffset = offsetOf(addrField, binaryPageMode);
                  next_pageWrap = (opcode == `OP_PAGE_READ);
                  next_dummyBits = dummyFor(opcode);
                  if (!knownRead(opcode)) begin
                     next_state = ST_IDLE;
                  end else if (opcode == `OP_SLOW_READ) begin
                     next_state = ST_DATA;
                     next_readActive = 1'b1;
                  end else begin
                     next_state = ST_DUMMY;
                     next_readActive = 1'b1;
                  end
               end
            end
         end
         ST_DUMMY: begin
            if (sckRise) begin
               next_bitCount = bitCount + 6'h01;
               if (dummyDone) begin
                  next_state = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (sckFall) begin
               // memory is only read, no buffer is written
               next_serialOut = curByte[bitIndex];
               next_serialOutEnable_n = 1'b0;
               next_bitIndex = bitIndex - 3'h1;
               if (byteDone) begin
                  if (pageEnd) begin
                     next_byteOffset = 10'h000;
                     next_pageNumber = nextPage(pageNumber, pageWrap);
                  end else begin
                     next_byteOffset = byteOffset + 10'h001;
                  end
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // either reset wins, then select high, then the command
   always @(posedge clk) begin
      if (!rst_n || rstPinLow) begin
         state <= ST_IDLE;
         shiftIn <= 32'h0;
         bitCount <= 6'h00;
         dummyBits <= 6'h00;
         opcode <= 8'h00;
         pageWrap <= 1'b0;
         pageNumber <= {PAGE_BITS{1'b0}};
         byteOffset <= 10'h000;
         bitIndex <= `BIT_INDEX_TOP;
         serialOut <= 1'b0;
         serialOutEnable_n <= 1'b1;
         readActive <= 1'b0;
      end else if (!csLow) begin
         // select high ends any read and floats the output
         state <= ST_IDLE;
         bitCount <= 6'h00;
         serialOutEnable_n <= 1'b1;
         readActive <= 1'b0;
      end else begin
         state <= next_state;
         shiftIn <= next_shiftIn;
         bitCount <= next_bitCount;
         dummyBits <= next_dummyBits;
         opcode <= next_opcode;
         pageWrap <= next_pageWrap;
         pageNumber <= next_pageNumber;
         byteOffset <= next_byteOffset;
         bitIndex <= next_bitIndex;
         serialOut <= next_serialOut;
         serialOutEnable_n <= next_serialOutEnable_n;
         readActive <= next_readActive;
      end
   end
endmodule

// >>> sim/flash_read_sva.sv
`timescale 1ns/1ps
module flash_read_sva (
   // watched pins
   input wire clk,
   input wire rst_n,
   input wire chipSelect_n,
   input wire serialClock,
   input wire resetPin_n,
   input wire serialOut,
   input wire serialOutEnable_n,
   input wire readActive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_TRI: assert property ($rose(chipSelect_n) |->
      ##[1:6] serialOutEnable_n) else $error("output not released");
   AST_IDLE: assert property (chipSelect_n[*8] |->
      serialOutEnable_n && !readActive) else $error("active unselected");
   AST_RPIN: assert property (!resetPin_n |-> ##[1:5]
      (!readActive && serialOutEnable_n)) else $error("reset pin ignored");
   AST_START: assert property ($rose(readActive) |-> !chipSelect_n)
      else $error("read without select");
   AST_DRIVE: assert property ($fell(serialOutEnable_n) |->
      !chipSelect_n && resetPin_n) else $error("bad drive start");
   AST_EDGE: assert property ($changed(serialOut) && !serialOutEnable_n
      |-> !serialClock) else $error("data moved on high clock");
   AST_HOLD: assert property ($rose(serialClock) && !serialOutEnable_n
      |=> $stable(serialOut)[*4]) else $error("data not held");
   AST_KEEP: assert property (
      (readActive && !chipSelect_n && resetPin_n)[*6] |=> readActive)
      else $error("read dropped");
endmodule

// >>> sim/spi_host.sv
`timescale 1ns/1ps
module spi_host (
   // pins
   output reg chipSelect_n,
   output reg serialClock,
   output reg serialIn,
   input wire serialLine,
   // received byte
   output reg [7:0] rx,
   output reg got
);
   initial {chipSelect_n, serialClock, serialIn, got, rx} = 12'h800;
   task bit1(input b);
      begin
         serialClock = 0;
         serialIn = b;
         #62.5 serialClock = 1;
         rx = {rx[6:0], serialLine};
         #62.5;
      end
   endtask
   // header sent from bit 63 down, then nb bytes read
   task read(input [63:0] hdr, input integer nh, nb, input m3);
      integer i;
      begin
         serialClock = m3;
         chipSelect_n = 0;
         #62.5;
         for (i = 63; i >= 64 - nh; i--) bit1(hdr[i]);
         for (i = 0; i < nb * 8; i++) begin
            bit1(~serialIn);
            if (i % 8 == 7) begin
               got = 1;
               #1 got = 0;
            end
         end
         chipSelect_n = 1;
         serialClock = m3;
      end
   endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "flash_read_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
$display("unexpected at %0t got %h exp %h", $time, a, b); end end
module testbench;
   reg clk = 0;
   reg rst_n = 0;
   reg resetPin_n = 1;
   reg binaryPageMode = 0;
   wire chipSelect_n, serialClock, serialIn, serialOut, serialOutEnable_n;
   wire readActive, got;
   wire [7:0] rx;
   integer errors = 0, n_tests = 0, seed = 32'h1523, i;
   integer dm [0:3] = '{32, 8, 0, 32};
   reg [7:0] ops [0:3] = '{`OP_LEGACY_READ, `OP_FAST_READ, `OP_SLOW_READ,
      `OP_PAGE_READ};
   reg [7:0] q[$];
   reg [7:0] expByte;
   reg [11:0] pg, np;
   reg [31:0] rnd;
   reg [23:0] a;
   serial_flash_read dut (.clk(clk), .rst_n(rst_n),
      .chipSelect_n(chipSelect_n), .serialClock(serialClock),
      .serialIn(serialIn), .resetPin_n(resetPin_n),
      .binaryPageMode(binaryPageMode), .serialOut(serialOut),
      .serialOutEnable_n(serialOutEnable_n), .readActive(readActive));
   spi_host host (.chipSelect_n(chipSelect_n), .serialClock(serialClock),
      .serialIn(serialIn), .rx(rx), .got(got),
      .serialLine(serialOutEnable_n ? ~serialOut : serialOut));
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   initial forever #4 clk = ~clk;
   always @(posedge got) begin
      expByte = q.size() ? q.pop_front() : 8'hxx;
      `CHK(rx, expByte)
   end
   initial begin
      #400000 errors++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1;
      // reset pin pulled low in the middle of a command
      @(posedge clk) #1 rnd = $random(seed);
      fork
         host.read({`OP_FAST_READ, rnd[23:0], rnd}, 40, 0, 0);
         begin
            repeat (520) @(posedge clk);
            #1 `CHK(readActive, 1'b1)
            resetPin_n = 0;
            repeat (4) @(posedge clk);
            #1 `CHK({readActive, serialOutEnable_n}, 2'b01)
            resetPin_n = 1;
         end
      join
      $display("reset pin test done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk) #1 binaryPageMode = i[2];
         pg = i > 5 ? 12'hfff : $random(seed);
         rnd = $random(seed);
         a = i[2] ? {rnd[2:0], pg, 9'h1fe} : {rnd[1:0], pg, 10'h20e};
         np = ops[i % 4] == `OP_PAGE_READ ? pg : pg + 12'h001;
         q.push_back({4'h0, pg[1:0], 2'h2} ^ 8'h5a);
         q.push_back({4'h0, pg[1:0], 2'h3} ^ 8'h5a);
         q.push_back({4'h0, np[1:0], 2'h0} ^ 8'h5a);
         host.read({ops[i % 4], a, rnd}, 32 + dm[i % 4], 3, i[0] ^ i[2]);
         repeat (8) @(posedge clk);
         #1 `CHK(serialOutEnable_n, 1'b1)
         $display("read test %0d done", i);
      end
      tally_and_finish;
   end
endmodule
bind serial_flash_read flash_read_sva chk (.clk(clk), .rst_n(rst_n),
   .chipSelect_n(chipSelect_n), .serialClock(serialClock),
   .resetPin_n(resetPin_n), .serialOut(serialOut),
   .serialOutEnable_n(serialOutEnable_n), .readActive(readActive));
